// file: verilog/spd_pkg.sv
package spd_pkg;
  // readout geometry and limits
  localparam int          DIGITS          = 5;
  localparam int          CNT_W           = 36;
  localparam int          VAL_W           = 20;
  localparam int          HIST_N          = 10;
  localparam logic [19:0] LOW_MOD         = 20'h186A0;  // 100000
  localparam logic [15:0] HIGH_LIM        = 16'h53E2;   // 21474
  localparam logic [19:0] LOW_LIM         = 20'h1869F;  // 99999
  localparam logic [15:0] FREQ_LIM        = 16'h1770;   // 6000
  localparam logic [15:0] SPEED_LIM       = 16'h1770;   // 6000
  localparam logic [15:0] TORQ_LIM        = 16'h012C;   // 300
  localparam logic [15:0] LOAD_LIM        = 16'h012C;   // 300
  localparam logic [15:0] BUS_LIM         = 16'h01F4;   // 500
  localparam logic [15:0] INERTIA_LIM     = 16'h0BB8;   // 3000 tenths
  localparam logic [15:0] INST_LIM        = 16'h0064;   // 100
  localparam logic [15:0] INDEX_HALF      = 16'h1388;   // 5000
  localparam logic [15:0] INDEX_PERIOD    = 16'h2710;   // 10000
  localparam logic [7:0]  NO_ALARM        = 8'h00;
  localparam logic [7:0]  OVERVOLTAGE_ALARM_CODE = 8'h01;
  // timing
  localparam int          CLK_HZ          = 25000000;
  localparam int          PEAK_WIN_S      = 15;
  localparam int          PEAK_SLOTS      = 15;
  localparam int          SLOT_CYCLES     = CLK_HZ * PEAK_WIN_S / PEAK_SLOTS;
  localparam int          BLINK_MS        = 250;
  localparam int          BLINK_CYCLES    = CLK_HZ / 1000 * BLINK_MS;
  // control modes of control_mode_setting
  localparam logic [2:0]  MODE_POS        = 3'h0;
  localparam logic [2:0]  MODE_POS_SPD    = 3'h1;
  localparam logic [2:0]  MODE_SPD        = 3'h2;
  localparam logic [2:0]  MODE_SPD_TRQ    = 3'h3;
  localparam logic [2:0]  MODE_TRQ        = 3'h4;
  localparam logic [2:0]  MODE_TRQ_POS    = 3'h5;
  // status items, index order of the up/down walk
  typedef enum logic [3:0] {
    IT_FB_LOW, IT_CMD_HIGH, IT_CMD_LOW, IT_DEVIATION, IT_CMD_FREQ, IT_SPEED,
    IT_ANALOG_SPEED, IT_SPEED_IN, IT_TORQUE, IT_LOAD, IT_PEAK, IT_BUS,
    IT_INERTIA, IT_INST, IT_INDEX
  } spd_item_type;
  localparam logic [3:0]  ITEM_LAST       = 4'hE;
endpackage

// file: verilog/spd_peak_hold.sv
`timescale 1ns/1ps
module spd_peak_hold
  import spd_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clr,
  input  wire logic [15:0] sample,
  output logic      [15:0] peak
);
  // one max per second slot; window max is the max of the slots
  logic [15:0] slot [PEAK_SLOTS];
  logic [3:0]  wr_idx;
  logic [31:0] tick;
  logic [15:0] next_peak;

  always_ff @(posedge clk)
  begin
    if (rst || clr)
    begin
      tick   <= 32'h0;
      wr_idx <= 4'h0;
      for (int i = 0; i < PEAK_SLOTS; i++)
        slot[i] <= 16'h0;
    end
    else if (tick == 32'(SLOT_LEN - 1))
    begin
      tick   <= 32'h0;
      wr_idx <= (wr_idx == 4'(PEAK_SLOTS - 1)) ? 4'h0 : wr_idx + 4'h1;
      slot[(wr_idx == 4'(PEAK_SLOTS - 1)) ? 4'h0 : wr_idx + 4'h1] <= sample;
    end
    else
    begin
      tick <= tick + 32'h1;
      if (sample > slot[wr_idx])
        slot[wr_idx] <= sample;
    end
  end

  always_comb
  begin
    next_peak = 16'h0;
    for (int i = 0; i < PEAK_SLOTS; i++)
      if (slot[i] > next_peak)
        next_peak = slot[i];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      peak <= 16'h0;
    else
      peak <= next_peak;
  end
endmodule // spd_peak_hold

// file: verilog/spd_alarm_hist.sv
`timescale 1ns/1ps
module spd_alarm_hist
  import spd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       push,
  input  wire logic [7:0] code,
  input  wire logic [3:0] rd_idx,
  output logic      [7:0] rd_code
);
  // shift register, entry 0 is the newest
  logic [7:0] mem [HIST_N];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < HIST_N; i++)
        mem[i] <= NO_ALARM;
    end
    else if (push)
    begin
      mem[0] <= code;
      for (int i = 1; i < HIST_N; i++)
        mem[i] <= mem[i-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_code <= NO_ALARM;
    else if (rd_idx < 4'(HIST_N))
      rd_code <= mem[rd_idx];
    else
      rd_code <= NO_ALARM;
  end
endmodule // spd_alarm_hist

// file: verilog/spd_status_display.sv
`timescale 1ns/1ps
module spd_status_display
  import spd_pkg::*;
#(
  parameter int PEAK_SLOT_LEN = SLOT_CYCLES,
  parameter int BLINK_LEN     = BLINK_CYCLES
)(
  // clock and reset
  input  wire logic              REF_CLK,
  input  wire logic              SRST,
  // panel buttons, one-cycle pulses
  input  wire logic              BTN_UP,
  input  wire logic              BTN_DOWN,
  input  wire logic              BTN_SET,
  input  wire logic              BTN_MODE,
  // drive state
  input  wire logic [2:0]        CONTROL_MODE_SETTING,
  input  wire logic              CMD_PULSE_STEP,
  input  wire logic              CMD_PULSE_DIR,
  input  wire logic              FB_PULSE_STEP,
  input  wire logic              FB_PULSE_DIR,
  input  wire logic signed [15:0] CMD_PULSE_FREQUENCY,
  input  wire logic signed [15:0] MOTOR_SPEED,
  input  wire logic signed [15:0] ANALOG_SPEED,
  input  wire logic signed [15:0] SPEED_LIMIT,
  input  wire logic signed [15:0] TORQUE_CMD,
  input  wire logic [15:0]       TORQUE_LIMIT,
  input  wire logic [15:0]       LOAD_RATE,
  input  wire logic [15:0]       TORQUE_ABS,
  input  wire logic [15:0]       BUS_VOLTAGE,
  input  wire logic              BUS_LOW,
  input  wire logic [15:0]       INERTIA_TENTHS,
  input  wire logic [15:0]       ENC_POS,
  input  wire logic              ENC_INDEX,
  // alarms
  input  wire logic [7:0]        ALARM_CODE,
  input  wire logic              ALARM_CAUSE,
  input  wire logic              EXTERNAL_ALARM_RESET,
  // display
  output logic signed [19:0]     DISP_VALUE,
  output logic [3:0]             DISP_ITEM,
  output logic                   DISP_ALARM_SCREEN,
  output logic                   DISP_HIST_SCREEN,
  output logic [3:0]             DISP_HIST_INDEX,
  output logic [7:0]             DISP_ALARM_NUM,
  output logic                   DISP_NO_ALARM,
  output logic                   DISP_BLANK,
  output logic                   BUS_UNDERVOLTAGE_TEXT,
  output logic                   DISP_DP4,
  output logic                   DISP_DP1,
  output logic                   ALARM_ACTIVE,
  output logic                   COUNTERS_CLEARED
);
  typedef enum logic [1:0] {SCR_STATUS, SCR_ALARM, SCR_HIST} spd_screen_type;

  spd_screen_type     screen;
  spd_item_type       item;
  logic [3:0]         hist_idx;
  logic               started;
  logic signed [35:0] cmd_before;
  logic signed [35:0] cmd_after;
  logic signed [35:0] fb_count;
  logic signed [15:0] enc_origin;
  logic [7:0]         alarm_now;
  logic               alarm_on;
  logic [31:0]        blink_cnt;
  logic               blink;
  logic               clr_counts;
  logic               clr_alarm;
  logic [15:0]        peak;
  logic [7:0]         hist_code;
  logic signed [35:0] deviation;
  logic signed [19:0] next_value;
  logic               next_neg5;

  // high part: drop five digits, clamp
  function automatic logic signed [19:0] high_part(input logic signed [35:0] v);
    logic signed [35:0] q;
    q = v / signed'(36'(LOW_MOD));
    if (q > signed'(36'(HIGH_LIM)))
      return 20'(HIGH_LIM);
    else if (q < -signed'(36'(HIGH_LIM)))
      return -20'(HIGH_LIM);
    else
      return q[19:0];
  endfunction

  // low part keeps the sign of the count, so rem stays within +-99999
  function automatic logic signed [19:0] low_part(input logic signed [35:0] v);
    logic signed [35:0] r;
    r = v % signed'(36'(LOW_MOD));
    return r[19:0];
  endfunction

  function automatic logic signed [19:0] clamp(input logic signed [19:0] v,
                                               input logic signed [19:0] lo,
                                               input logic signed [19:0] hi);
    if (v > hi)
      return hi;
    else if (v < lo)
      return lo;
    else
      return v;
  endfunction

  assign clr_counts = BTN_SET && screen == SCR_STATUS && started;
  assign clr_alarm  = (BTN_SET && screen == SCR_ALARM) || EXTERNAL_ALARM_RESET;
  assign deviation  = cmd_before - fb_count;

  // counters carry 36 bits, more than ten decimal digits
  always_ff @(posedge REF_CLK)
  begin
    if (SRST || clr_counts)
    begin
      cmd_before <= 36'sh0;
      cmd_after  <= 36'sh0;
      fb_count   <= 36'sh0;
    end
    else
    begin
      if (CMD_PULSE_STEP)
      begin
        cmd_before <= CMD_PULSE_DIR ? cmd_before - 36'sh1 : cmd_before + 36'sh1;
        cmd_after  <= CMD_PULSE_DIR ? cmd_after - 36'sh1 : cmd_after + 36'sh1;
      end
      if (FB_PULSE_STEP)
        fb_count <= FB_PULSE_DIR ? fb_count - 36'sh1 : fb_count + 36'sh1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      COUNTERS_CLEARED <= 1'b0;
    else
      COUNTERS_CLEARED <= clr_counts;
  end

  // encoder position latched at each index pulse
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      enc_origin <= 16'sh0;
    else if (ENC_INDEX)
      enc_origin <= signed'(ENC_POS);
  end

  // item walk and screen selection
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      started  <= 1'b0;
      item     <= IT_FB_LOW;
      screen   <= SCR_STATUS;
      hist_idx <= 4'h0;
    end
    else if (!started)
    begin
      started <= 1'b1;
      case (CONTROL_MODE_SETTING)
        MODE_POS, MODE_POS_SPD: item <= IT_FB_LOW;
        MODE_SPD, MODE_SPD_TRQ: item <= IT_SPEED;
        MODE_TRQ, MODE_TRQ_POS: item <= IT_TORQUE;
        default:                item <= IT_FB_LOW;
      endcase
    end
    else if (BTN_MODE)
    begin
      case (screen)
        SCR_STATUS: screen <= SCR_ALARM;
        SCR_ALARM:  screen <= SCR_HIST;
        SCR_HIST:   screen <= SCR_STATUS;
        default:    screen <= SCR_STATUS;
      endcase
      hist_idx <= 4'h0;
    end
    else if (screen == SCR_STATUS)
    begin
      if (BTN_UP)
        item <= (item == spd_item_type'(ITEM_LAST)) ? IT_FB_LOW : spd_item_type'(item + 4'h1);
      else if (BTN_DOWN)
        item <= (item == IT_FB_LOW) ? spd_item_type'(ITEM_LAST) : spd_item_type'(item - 4'h1);
    end
    else if (screen == SCR_HIST)
    begin
      if (BTN_DOWN && hist_idx != 4'(HIST_N - 1))
        hist_idx <= hist_idx + 4'h1;
      else if (BTN_UP && hist_idx != 4'h0)
        hist_idx <= hist_idx - 4'h1;
    end
  end

  // combined modes open on the first of their two items
  // alarm latch: cause sets, clear needs the cause gone; set beats clear
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      alarm_on  <= 1'b0;
      alarm_now <= NO_ALARM;
    end
    else if (ALARM_CAUSE && !alarm_on)
    begin
      alarm_on  <= 1'b1;
      alarm_now <= ALARM_CODE;
    end
    else if (clr_alarm && !ALARM_CAUSE)
    begin
      alarm_on  <= 1'b0;
      alarm_now <= NO_ALARM;
    end
  end

  spd_alarm_hist u_hist (
    .clk     (REF_CLK),
    .rst     (SRST),
    .push    (ALARM_CAUSE && !alarm_on),
    .code    (ALARM_CODE),
    .rd_idx  (hist_idx),
    .rd_code (hist_code)
  );

  spd_peak_hold #(.SLOT_LEN(PEAK_SLOT_LEN)) u_peak (
    .clk    (REF_CLK),
    .rst    (SRST),
    .clr    (1'b0),
    .sample (TORQUE_ABS),
    .peak   (peak)
  );

  // blink divider
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
    end
    else if (blink_cnt == 32'(BLINK_LEN - 1))
    begin
      blink_cnt <= 32'h0;
      blink     <= ~blink;
    end
    else
      blink_cnt <= blink_cnt + 32'h1;
  end

  // value selection
  always_comb
  begin
    next_value = 20'sh0;
    next_neg5  = 1'b0;
    case (item)
      IT_FB_LOW:       next_value = low_part(fb_count);
      IT_CMD_HIGH:     next_value = high_part(cmd_after);
      IT_CMD_LOW:      next_value = low_part(cmd_after);
      IT_DEVIATION:    next_value = low_part(deviation);
      IT_CMD_FREQ:     next_value = clamp(20'(CMD_PULSE_FREQUENCY),
                                          -20'(FREQ_LIM), 20'(FREQ_LIM));
      IT_SPEED:        next_value = clamp(20'(MOTOR_SPEED),
                                          -20'(SPEED_LIM), 20'(SPEED_LIM));
      IT_ANALOG_SPEED:
      begin
        if (CONTROL_MODE_SETTING == MODE_SPD || CONTROL_MODE_SETTING == MODE_TRQ)
          next_value = 20'sh0;
        else
          next_value = 20'sh0;
      end
      IT_SPEED_IN:     next_value = (CONTROL_MODE_SETTING == MODE_TRQ) ?
                         clamp(20'(SPEED_LIMIT), -20'(SPEED_LIM), 20'(SPEED_LIM)) :
                         clamp(20'(ANALOG_SPEED), -20'(SPEED_LIM), 20'(SPEED_LIM));
      IT_TORQUE:       next_value = (CONTROL_MODE_SETTING == MODE_TRQ) ?
                         clamp(20'(TORQUE_CMD), -20'(TORQ_LIM), 20'(TORQ_LIM)) :
                         clamp(20'({4'h0, TORQUE_LIMIT}), 20'sh0, 20'(TORQ_LIM));
      IT_LOAD:         next_value = clamp(20'({4'h0, LOAD_RATE}),
                                          20'sh0, 20'(LOAD_LIM));
      IT_PEAK:         next_value = clamp(20'({4'h0, peak}),
                                          20'sh0, 20'(LOAD_LIM));
      IT_BUS:          next_value = clamp(20'({4'h0, BUS_VOLTAGE}),
                                          20'sh0, 20'(BUS_LIM));
      IT_INERTIA:      next_value = clamp(20'({4'h0, INERTIA_TENTHS}),
                                          20'sh0, 20'(INERTIA_LIM));
      IT_INST:         next_value = clamp(20'({4'h0, TORQUE_ABS}),
                                          20'sh0, 20'(INST_LIM));
      IT_INDEX:
      begin
        next_value = 20'(signed'(ENC_POS - enc_origin));
        if (next_value > signed'(20'(INDEX_HALF)))
          next_value = next_value - 20'(INDEX_PERIOD);
        else if (next_value <= -signed'(20'(INDEX_HALF)))
          next_value = next_value + 20'(INDEX_PERIOD);
      end
      default:         next_value = 20'sh0;
    endcase
    next_neg5 = next_value < -20'sh270F;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      DISP_VALUE            <= 20'sh0;
      DISP_ITEM             <= 4'h0;
      DISP_ALARM_SCREEN     <= 1'b0;
      DISP_HIST_SCREEN      <= 1'b0;
      DISP_HIST_INDEX       <= 4'h0;
      DISP_ALARM_NUM        <= NO_ALARM;
      DISP_NO_ALARM         <= 1'b0;
      DISP_BLANK            <= 1'b0;
      BUS_UNDERVOLTAGE_TEXT <= 1'b0;
      DISP_DP4              <= 1'b0;
      DISP_DP1              <= 1'b0;
      ALARM_ACTIVE          <= 1'b0;
    end
    else
    begin
      DISP_VALUE            <= next_value;
      DISP_ITEM             <= item;
      DISP_ALARM_SCREEN     <= screen == SCR_ALARM;
      DISP_HIST_SCREEN      <= screen == SCR_HIST;
      DISP_HIST_INDEX       <= hist_idx;
      DISP_ALARM_NUM        <= (screen == SCR_HIST) ? hist_code : alarm_now;
      DISP_NO_ALARM         <= screen == SCR_ALARM && !alarm_on;
      DISP_BLANK            <= screen == SCR_ALARM && alarm_on && blink;
      BUS_UNDERVOLTAGE_TEXT <= item == IT_BUS && BUS_LOW;
      DISP_DP4              <= screen == SCR_STATUS && alarm_on && blink;
      DISP_DP1              <= screen == SCR_STATUS && next_neg5;
      ALARM_ACTIVE          <= alarm_on;
    end
  end
endmodule // spd_status_display

// file: bench/spd_status_props.sv
`timescale 1ns/1ps
module spd_status_props
  import spd_pkg::*;
(
  // clock and reset
  input  wire logic               REF_CLK,
  input  wire logic               SRST,
  // watched inputs
  input  wire logic [2:0]         CONTROL_MODE_SETTING,
  input  wire logic               BUS_LOW,
  input  wire logic               ALARM_CAUSE,
  // watched outputs
  input  wire logic signed [19:0] DISP_VALUE,
  input  wire logic [3:0]         DISP_ITEM,
  input  wire logic               DISP_ALARM_SCREEN,
  input  wire logic               DISP_HIST_SCREEN,
  input  wire logic [3:0]         DISP_HIST_INDEX,
  input  wire logic               DISP_BLANK,
  input  wire logic               BUS_UNDERVOLTAGE_TEXT,
  input  wire logic               DISP_DP4,
  input  wire logic               ALARM_ACTIVE,
  input  wire logic               COUNTERS_CLEARED
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  logic       stat_q;
  logic [3:0] item_q;
  wire        stat = !DISP_ALARM_SCREEN && !DISP_HIST_SCREEN;
  // a value is judged only once item and screen have settled for a cycle
  wire        steady = stat && stat_q && (DISP_ITEM == item_q);
  wire  [3:0] first_item = (CONTROL_MODE_SETTING < 3'h2) ? 4'h0 :
                           (CONTROL_MODE_SETTING < 3'h4) ? 4'h5 : 4'h8;
  always_ff @(posedge REF_CLK)
  begin
    stat_q <= stat;
    item_q <= DISP_ITEM;
  end
  property p_init; $fell(SRST) |-> ##[1:3] (DISP_ITEM == first_item); endproperty
  a_init: assert property (p_init) else $error("initial item wrong");
  property p_clr; COUNTERS_CLEARED |=> !COUNTERS_CLEARED; endproperty
  a_clr: assert property (p_clr) else $error("clear pulse too long");
  property p_five; DISP_VALUE >= -99999 && DISP_VALUE <= 99999; endproperty
  a_five: assert property (p_five) else $error("value beyond five digits");
  property p_high; steady && DISP_ITEM == 4'h1 |-> DISP_VALUE >= -21474 && DISP_VALUE <= 21474; endproperty
  a_high: assert property (p_high) else $error("high part out of range");
  property p_freq; steady && DISP_ITEM == 4'h4 |-> DISP_VALUE >= -6000 && DISP_VALUE <= 6000; endproperty
  a_freq: assert property (p_freq) else $error("frequency out of range");
  property p_analog; steady && DISP_ITEM == 4'h6 |-> DISP_VALUE == 0; endproperty
  a_analog: assert property (p_analog) else $error("analog item not zero");
  property p_torq; steady && DISP_ITEM == 4'h8 |-> DISP_VALUE >= -300 && DISP_VALUE <= 300; endproperty
  a_torq: assert property (p_torq) else $error("torque item out of range");
  property p_load; steady && DISP_ITEM == 4'h9 |-> DISP_VALUE >= 0 && DISP_VALUE <= 300; endproperty
  a_load: assert property (p_load) else $error("load rate out of range");
  property p_inst; steady && DISP_ITEM == 4'hD |-> DISP_VALUE >= 0 && DISP_VALUE <= 100; endproperty
  a_inst: assert property (p_inst) else $error("torque now out of range");
  property p_index; steady && DISP_ITEM == 4'hE |-> DISP_VALUE >= -4999 && DISP_VALUE <= 5000; endproperty
  a_index: assert property (p_index) else $error("index position out of range");
  property p_uv; BUS_LOW && steady && DISP_ITEM == 4'hB |-> ##[1:2] BUS_UNDERVOLTAGE_TEXT; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage text missing");
  property p_raise; ALARM_CAUSE |-> ##[1:2] ALARM_ACTIVE; endproperty
  a_raise: assert property (p_raise) else $error("alarm not raised");
  property p_hold; ALARM_ACTIVE && ALARM_CAUSE && $past(ALARM_CAUSE) |=> ALARM_ACTIVE; endproperty
  a_hold: assert property (p_hold) else $error("alarm cleared with cause present");
  property p_quiet; !ALARM_ACTIVE [*3] |-> !DISP_DP4 && !DISP_BLANK; endproperty
  a_quiet: assert property (p_quiet) else $error("blink without alarm");
  property p_hidx; DISP_HIST_INDEX <= 4'h9; endproperty
  a_hidx: assert property (p_hidx) else $error("history index past ten");
endmodule // spd_status_props

bind spd_status_display spd_status_props chk_u (.REF_CLK, .SRST, .CONTROL_MODE_SETTING,
  .BUS_LOW, .ALARM_CAUSE, .DISP_VALUE, .DISP_ITEM, .DISP_ALARM_SCREEN, .DISP_HIST_SCREEN,
  .DISP_HIST_INDEX, .DISP_BLANK, .BUS_UNDERVOLTAGE_TEXT, .DISP_DP4, .ALARM_ACTIVE,
  .COUNTERS_CLEARED);

// file: bench/spd_panel_model.sv
`timescale 1ns/1ps
module spd_panel_model
  import spd_pkg::*;
(
  // clock and request: 1 up, 2 down, 3 set, 4 mode
  input  wire logic       clk,
  input  wire logic [2:0] req,
  // buttons
  output logic            btn_up,
  output logic            btn_down,
  output logic            btn_set,
  output logic            btn_mode
);
  // one key, one clock long, as a debounced key gives
  always_ff @(posedge clk)
  begin
    btn_up   <= (req == 3'h1);
    btn_down <= (req == 3'h2);
    btn_set  <= (req == 3'h3);
    btn_mode <= (req == 3'h4);
  end
endmodule // spd_panel_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import spd_pkg::*;
;
  logic               clk, srst, cstep, cdir, fstep, fdir, eidx, blow, acause, ares;
  logic               b_up, b_dn, b_set, b_mode, d_asc, d_hsc, d_noal, d_blank, d_uv, d_dp4;
  logic               d_dp1, d_act, d_clr, seen;
  logic [2:0]         mode, req;
  logic signed [15:0] freq, speed, aspeed, slimit, tcmd;
  logic [15:0]        tlim, load, tabs, busv, inert, epos;
  logic [7:0]         acode, d_anum;
  logic [3:0]         d_item, d_hidx;
  logic signed [19:0] d_val;
  logic signed [19:0] exp_val [15];
  int                 n_mismatch, num_checks, i, a, b;

  spd_status_display #(.PEAK_SLOT_LEN(10), .BLINK_LEN(4)) dut_u (.REF_CLK(clk), .SRST(srst),
    .BTN_UP(b_up), .BTN_DOWN(b_dn), .BTN_SET(b_set), .BTN_MODE(b_mode),
    .CONTROL_MODE_SETTING(mode), .CMD_PULSE_STEP(cstep), .CMD_PULSE_DIR(cdir),
    .FB_PULSE_STEP(fstep), .FB_PULSE_DIR(fdir), .CMD_PULSE_FREQUENCY(freq),
    .MOTOR_SPEED(speed), .ANALOG_SPEED(aspeed), .SPEED_LIMIT(slimit), .TORQUE_CMD(tcmd),
    .TORQUE_LIMIT(tlim), .LOAD_RATE(load), .TORQUE_ABS(tabs), .BUS_VOLTAGE(busv),
    .BUS_LOW(blow), .INERTIA_TENTHS(inert), .ENC_POS(epos), .ENC_INDEX(eidx),
    .ALARM_CODE(acode), .ALARM_CAUSE(acause), .EXTERNAL_ALARM_RESET(ares),
    .DISP_VALUE(d_val), .DISP_ITEM(d_item), .DISP_ALARM_SCREEN(d_asc),
    .DISP_HIST_SCREEN(d_hsc), .DISP_HIST_INDEX(d_hidx), .DISP_ALARM_NUM(d_anum),
    .DISP_NO_ALARM(d_noal), .DISP_BLANK(d_blank), .BUS_UNDERVOLTAGE_TEXT(d_uv),
    .DISP_DP4(d_dp4), .DISP_DP1(d_dp1), .ALARM_ACTIVE(d_act), .COUNTERS_CLEARED(d_clr));
  spd_panel_model panel_u (.clk(clk), .req(req), .btn_up(b_up), .btn_down(b_dn),
    .btn_set(b_set), .btn_mode(b_mode));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic signed [19:0] e, input logic signed [19:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // the key reaches the logic a clock after the request, the screen two more later
  task automatic press(input logic [2:0] code);
    req = code;
    step(1);
    req = 3'h0;
    step(4);
  endtask
  task automatic blinks(output int nd, output int nb);
    logic pd;
    logic pb;
    nd = 0;
    nb = 0;
    pd = d_dp4;
    pb = d_blank;
    repeat (20)
    begin
      step(1);
      nd += int'(d_dp4 !== pd);
      nb += int'(d_blank !== pb);
      pd = d_dp4;
      pb = d_blank;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // the whole sequence needs well under two thousand cycles
  initial
  begin
    step(20000);
    n_mismatch++;
    $display("unexpected watchdog expected done seen hang");
    give_verdict;
  end

  initial
  begin
    {srst, cstep, fstep, eidx, blow, acause, ares, req} = {1'b1, 9'h0};
    {cdir, fdir, mode, acode} = {1'b1, 1'b0, 3'h2, OVERVOLTAGE_ALARM_CODE};
    {freq, speed, aspeed, slimit, tcmd} = {-16'sh1B58, -16'shBB8, 16'sh4D2, 16'sh3E8, 16'sh64};
    {tlim, load, tabs, busv, inert, epos} = {16'hFA, 16'h190, 16'h96, 16'h140, 16'h9B, 16'h64};
    exp_val = '{20'sh5, 20'sh0, -20'sh3, -20'sh8, -20'sh1770, -20'shBB8, 20'sh0, 20'sh4D2,
      20'shFA, 20'sh12C, 20'sh96, 20'sh140, 20'sh9B, 20'sh64, -20'shBB8};
    step(3);
    srst = 1'b0;
    chk("alarm after restart", 1'b0, d_act);
    step(3);
    chk("initial item", 20'sh5, d_item);
    for (i = 0; i < 5; i++)
    begin
      cstep = (i < 3);
      fstep = 1'b1;
      eidx = (i == 0);
      step(1);
      {cstep, fstep, eidx} = 3'h0;
      step(1);
    end
    epos = 16'h1BBC;
    step(20);
    repeat (5) press(3'h2);
    for (i = 0; i < 15; i++)
    begin
      chk("item", 20'(i), d_item);
      chk("value", exp_val[i], d_val);
      chk("five-digit sign", 1'b0, d_dp1);
      if (i == 11)
      begin
        blow = 1'b1;
        step(3);
        chk("undervoltage text", 1'b1, d_uv);
        blow = 1'b0;
      end
      if (i < 14)
        press(3'h1);
    end
    repeat (11) press(3'h2);
    req = 3'h3;
    step(1);
    req = 3'h0;
    seen = 1'b0;
    repeat (6)
    begin
      step(1);
      seen |= d_clr;
    end
    chk("clear pulse", 1'b1, seen);
    chk("deviation after clear", 20'sh0, d_val);
    acause = 1'b1;
    step(3);
    chk("alarm active", 1'b1, d_act);
    blinks(a, b);
    chk("dp4 blinks", 1'b1, a > 1);
    chk("item readable", 20'sh3, d_item);
    press(3'h4);
    chk("alarm screen", 1'b1, d_asc);
    chk("alarm number", 20'sh1, d_anum);
    blinks(a, b);
    chk("code blinks", 1'b1, b > 1);
    press(3'h3);
    chk("clear refused", 1'b1, d_act);
    acause = 1'b0;
    press(3'h3);
    chk("alarm cleared", 1'b0, d_act);
    chk("no alarm text", 1'b1, d_noal);
    acode = 8'h02;
    acause = 1'b1;
    step(3);
    acause = 1'b0;
    ares = 1'b1;
    step(1);
    ares = 1'b0;
    step(3);
    chk("external reset clear", 1'b0, d_act);
    press(3'h4);
    press(3'h1);
    chk("history screen", 1'b1, d_hsc);
    chk("newest index", 20'sh0, d_hidx);
    chk("newest code", 20'sh2, d_anum);
    press(3'h2);
    chk("older index", 20'sh1, d_hidx);
    chk("older code", 20'sh1, d_anum);
    press(3'h4);
    chk("back on status", 20'sh0, {d_asc, d_hsc});
    for (i = 0; i < 6; i++)
    begin
      mode = i[2:0];
      srst = 1'b1;
      step(3);
      srst = 1'b0;
      step(3);
      chk("initial item", (i < 2) ? 20'sh0 : (i < 4) ? 20'sh5 : 20'sh8, d_item);
      if (i == 4)
      begin
        chk("torque command", 20'sh64, d_val);
        press(3'h2);
        chk("speed limit", 20'sh3E8, d_val);
      end
    end
    give_verdict;
  end
endmodule // testbench
